// File: rtl/pin_mux_pkg.sv
package pin_mux_pkg;

   // -------------------------------------------------------------
   // Sizes and reset values
   // -------------------------------------------------------------
   localparam int          LINE_COUNT       = 32;
   localparam int          CTRL_COUNT       = 3;
   localparam int          CTRL_FIRST       = 0;
   localparam int          CTRL_THIRD       = 2;
   // Lines 30 and 31 of the first controller reset as address outputs
   localparam logic [31:0] RESET_OWNER_FIRST = 32'hC0000000;
   // Line 3 of the third controller resets as an address output
   localparam logic [31:0] RESET_OWNER_THIRD = 32'h00000008;
   localparam logic [31:0] RESET_SELECT_B    = 32'hC0000000;
   localparam logic [31:0] RESET_OTHER       = 32'h00000000;
   localparam int          WAIT_LINE         = 2;

   // -------------------------------------------------------------
   // Carrier types
   // -------------------------------------------------------------
   typedef enum logic [1:0] {
      SEL_GPIO = 2'b00,
      SEL_A    = 2'b01,
      SEL_B    = 2'b10
   } line_sel_type;

   typedef struct packed {
      logic out;
      logic oe_n;
   } pad_drive_type;

endpackage

// File: rtl/pin_line_select.sv
`timescale 1ns/1ns
module pin_line_select
   import pin_mux_pkg::*;
(
   input  wire logic          owner,
   input  wire logic          select_b,
   input  wire pad_drive_type gpio_drv,
   input  wire pad_drive_type per_a_drv,
   input  wire pad_drive_type per_b_drv,
   output pad_drive_type      pad_drv
);

   // -------------------------------------------------------------
   // Per-line selector
   // -------------------------------------------------------------
   always_comb begin
      if (!owner) begin
         pad_drv = gpio_drv;
      end else if (select_b) begin
         pad_drv = per_b_drv;
      end else begin
         pad_drv = per_a_drv;
      end
   end

endmodule

// File: rtl/pio_peripheral_pin_mux.sv
// Function
// - Each controller has up to 32 lines, each GPIO or one of functions A/B.
// - An I/O-reset line leaves reset as input with pull-up, owner bit zero.
// - A function-reset line leaves reset routed to it, owner bit one.
// - Pull-ups are enabled at reset for function-reset lines as well.
// - One output-only peripheral signal may drive several lines alike.
// - Software can disable the bus wait request input, freeing its pin.
// - 16 bpp panels use B-function display data and intensity lines.
// - spi_first is function A and memory_card_iface function B, same lines.
`timescale 1ns/1ns
module pio_peripheral_pin_mux
   import pin_mux_pkg::*;
#(
   parameter int LINES = LINE_COUNT
)
(
   input  wire logic                               sys_clk,
   input  wire logic                               reset_n,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   owner_set,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   owner_clear,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   select_a_set,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   select_b_set,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   pullup_disable,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   pullup_enable,
   input  wire logic                               wait_disable,
   input  wire logic                               wait_enable,
   input  wire pad_drive_type [CTRL_COUNT-1:0][LINES-1:0] gpio_drv,
   input  wire pad_drive_type [CTRL_COUNT-1:0][LINES-1:0] per_a_drv,
   input  wire pad_drive_type [CTRL_COUNT-1:0][LINES-1:0] per_b_drv,
   input  wire logic [CTRL_COUNT-1:0][LINES-1:0]   pad_in,
   output pad_drive_type [CTRL_COUNT-1:0][LINES-1:0] pad_drv,
   output logic [CTRL_COUNT-1:0][LINES-1:0]        pullup_on,
   output logic [CTRL_COUNT-1:0][LINES-1:0]        line_owner_status_reg,
   output logic [CTRL_COUNT-1:0][LINES-1:0]        select_b_status,
   output logic                                    wait_active,
   output logic                                    bus_wait_request
);

   // -------------------------------------------------------------
   // Parameter check
   // -------------------------------------------------------------
   if (LINES < 1 || LINES > LINE_COUNT) begin : g_bad_lines
      $error("LINES must be 1 to 32");
   end

   if (WAIT_LINE >= LINES) begin : g_bad_wait
      $error("LINES too small for the wait line");
   end

   function automatic logic [LINES-1:0] owner_reset(input int ctrl);
      if (ctrl == CTRL_FIRST) begin
         owner_reset = RESET_OWNER_FIRST[LINES-1:0];
      end else if (ctrl == CTRL_THIRD) begin
         owner_reset = RESET_OWNER_THIRD[LINES-1:0];
      end else begin
         owner_reset = RESET_OTHER[LINES-1:0];
      end
   endfunction

   function automatic logic [LINES-1:0] select_reset(input int ctrl);
      if (ctrl == CTRL_FIRST) begin
         select_reset = RESET_SELECT_B[LINES-1:0];
      end else begin
         select_reset = RESET_OTHER[LINES-1:0];
      end
   endfunction

   // -------------------------------------------------------------
   // Line ownership and function select
   // -------------------------------------------------------------
   for (genvar c = 0; c < CTRL_COUNT; c++) begin : g_ctrl
      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            line_owner_status_reg[c] <= owner_reset(c);
         end else begin
            line_owner_status_reg[c] <=
               (line_owner_status_reg[c] & ~owner_clear[c]) | owner_set[c];
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            select_b_status[c] <= select_reset(c);
         end else begin
            // One select per line; B wins a same-cycle tie
            select_b_status[c] <=
               (select_b_status[c] & ~select_a_set[c]) | select_b_set[c];
         end
      end

      always_ff @(posedge sys_clk) begin
         if (!reset_n) begin
            pullup_on[c] <= '1;
         end else begin
            pullup_on[c] <= (pullup_on[c] & ~pullup_disable[c])
                            | pullup_enable[c];
         end
      end

      // Shared peripheral outputs fan to every selecting line
      for (genvar l = 0; l < LINES; l++) begin : g_line
         pin_line_select u_sel (
            .owner     (line_owner_status_reg[c][l]),
            .select_b  (select_b_status[c][l]),
            .gpio_drv  (gpio_drv[c][l]),
            .per_a_drv (per_a_drv[c][l]),
            .per_b_drv (per_b_drv[c][l]),
            .pad_drv   (pad_drv[c][l])
         );

         line_route_a: assert property (@(posedge sys_clk)
            disable iff (!reset_n)
            line_owner_status_reg[c][l]
            |-> pad_drv[c][l] == (select_b_status[c][l] ? per_b_drv[c][l]
                                                          : per_a_drv[c][l]))
            else $error("owned line not on its function");
      end
   end

   // -------------------------------------------------------------
   // Bus wait request gating
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         wait_active <= 1'b1;
      end else if (wait_enable) begin
         wait_active <= 1'b1;
      end else if (wait_disable) begin
         wait_active <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         bus_wait_request <= 1'b0;
      end else begin
         bus_wait_request <= wait_active
            && line_owner_status_reg[CTRL_THIRD][WAIT_LINE]
            && !select_b_status[CTRL_THIRD][WAIT_LINE]
            && !pad_in[CTRL_THIRD][WAIT_LINE];
      end
   end

   // -------------------------------------------------------------
   // Checks
   // -------------------------------------------------------------
   owner_reset_a: assert property (@(posedge sys_clk)
      reset_n && !$past(reset_n)
      |-> line_owner_status_reg[CTRL_FIRST]
             == RESET_OWNER_FIRST[LINES-1:0]
         && line_owner_status_reg[CTRL_THIRD]
             == RESET_OWNER_THIRD[LINES-1:0])
      else $error("owner bit wrong after reset");

   select_reset_a: assert property (@(posedge sys_clk)
      reset_n && !$past(reset_n)
      |-> select_b_status[CTRL_FIRST] == RESET_SELECT_B[LINES-1:0]
         && select_b_status[CTRL_THIRD] == RESET_OTHER[LINES-1:0])
      else $error("select bits wrong after reset");

   pullup_reset_a: assert property (@(posedge sys_clk)
      reset_n && !$past(reset_n) |-> pullup_on == '1)
      else $error("pull-up off after reset");

   io_reset_a: assert property (@(posedge sys_clk)
      reset_n && !$past(reset_n) |-> line_owner_status_reg[1] == '0)
      else $error("io line owner not zero");

   wait_reset_a: assert property (@(posedge sys_clk)
      reset_n && !$past(reset_n) |-> wait_active && !bus_wait_request)
      else $error("wait state wrong after reset");

   gpio_route_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      !line_owner_status_reg[0][0] |-> pad_drv[0][0] == gpio_drv[0][0])
      else $error("gpio line not driven by gpio");

   b_route_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      line_owner_status_reg[1][5] && select_b_status[1][5]
      |-> pad_drv[1][5] == per_b_drv[1][5])
      else $error("function B not routed");

   a_route_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      line_owner_status_reg[0][0] && !select_b_status[0][0]
      |-> pad_drv[0][0] == per_a_drv[0][0])
      else $error("function A not routed");

   owner_set_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      owner_set[0][0] |=> line_owner_status_reg[0][0])
      else $error("owner set lost");

   owner_clear_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      owner_clear[1][5] && !owner_set[1][5]
      |=> !line_owner_status_reg[1][5])
      else $error("owner clear lost");

   select_tie_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      select_a_set[0][0] && select_b_set[0][0] |=> select_b_status[0][0])
      else $error("select tie not won by B");

   a_pick_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      select_a_set[0][0] && !select_b_set[0][0]
      |=> !select_b_status[0][0])
      else $error("function A not selected");

   pullup_tie_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pullup_disable[0][0] && pullup_enable[0][0] |=> pullup_on[0][0])
      else $error("pull-up tie not won by enable");

   pullup_off_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pullup_disable[0][31] && !pullup_enable[0][31]
      |=> !pullup_on[0][31])
      else $error("pull-up not turned off");

   wait_tie_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      wait_disable && wait_enable |=> wait_active)
      else $error("wait tie not won by enable");

   wait_off_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      !wait_active |=> !bus_wait_request)
      else $error("wait seen while disabled");

   wait_high_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      pad_in[CTRL_THIRD][WAIT_LINE] |=> !bus_wait_request)
      else $error("wait seen with pad high");

   irq_share_a: assert property (@(posedge sys_clk)
      disable iff (!reset_n)
      select_b_status[CTRL_THIRD][WAIT_LINE] |=> !bus_wait_request)
      else $error("wait seen on function B");

endmodule

// File: testbench/pin_pad_model.sv
`timescale 1ns/1ns
module pin_pad_model
   import pin_mux_pkg::*;
(
   input  wire logic          sys_clk,
   input  wire logic          wait_pad,
   input  wire pad_drive_type [2:0][31:0] pad_drv,
   input  wire logic [2:0][31:0] pullup_on,
   output pad_drive_type      [2:0][31:0] gpio_drv,
   output pad_drive_type      [2:0][31:0] per_a_drv,
   output pad_drive_type      [2:0][31:0] per_b_drv,
   output logic [2:0][31:0]   pad_in
);
   // --------------------------------------------
   // Sources and pads
   // --------------------------------------------
   logic tog = 1'b0;
   always @(posedge sys_clk) tog <= ~tog;
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         for (int l = 0; l < 32; l++) begin
            gpio_drv[c][l] = '{out: tog, oe_n: 1'b1};
            per_a_drv[c][l] = '{out: tog, oe_n: 1'b0};
            per_b_drv[c][l] = '{out: ~tog, oe_n: 1'b0};
         end
      end
      per_a_drv[2][2] = '{out: 1'b0, oe_n: 1'b1};
   end
   always_comb begin
      for (int c = 0; c < 3; c++) begin
         for (int l = 0; l < 32; l++) begin
            if (pad_drv[c][l].oe_n === 1'b0)
               pad_in[c][l] = pad_drv[c][l].out;
            else
               pad_in[c][l] = pullup_on[c][l] ? 1'b1 : tog;
         end
      end
      pad_in[2][2] = wait_pad;
   end
endmodule

// File: testbench/pio_peripheral_pin_mux_bench.sv
`timescale 1ns/1ns
module pio_peripheral_pin_mux_bench
   import pin_mux_pkg::*;
;
   // --------------------------------------------
   // Bench
   // --------------------------------------------
   typedef logic [2:0][31:0] vec_type;
   logic    sys_clk = 1'b0;
   logic    reset_n = 1'b0;
   logic    wait_pad = 1'b0;
   logic    wd = 1'b0;
   logic    we = 1'b0;
   logic    wa, swd, swe, spad, ew, wact, wreq;
   vec_type drv [6];
   vec_type st [6];
   vec_type own, selb, pu, pin, puo, osr, bsr;
   int      bad_count = 0;
   int      cmp_count = 0;
   int      cyc = 0;
   pad_drive_type [2:0][31:0] pd, gd, ad, bd, ep;
   pio_peripheral_pin_mux pio_peripheral_pin_mux_inst (.sys_clk(sys_clk),
      .reset_n(reset_n), .owner_set(drv[0]), .owner_clear(drv[1]),
      .select_a_set(drv[2]), .select_b_set(drv[3]),
      .pullup_disable(drv[4]), .pullup_enable(drv[5]), .wait_disable(wd),
      .wait_enable(we), .gpio_drv(gd), .per_a_drv(ad), .per_b_drv(bd),
      .pad_in(pin), .pad_drv(pd), .pullup_on(puo),
      .line_owner_status_reg(osr), .select_b_status(bsr),
      .wait_active(wact), .bus_wait_request(wreq));
   pin_pad_model pin_pad_model_inst (.sys_clk(sys_clk), .wait_pad(wait_pad),
      .pad_drv(pd), .pullup_on(puo), .gpio_drv(gd), .per_a_drv(ad),
      .per_b_drv(bd), .pad_in(pin));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 1000) begin
         bad_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [191:0] seen, input logic [191:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h",
                  $time, seen, exp);
      end
   endtask
   task automatic arm(input int k, input int c, input logic [31:0] m);
      st[k][c] = st[k][c] | m;
   endtask
   task automatic tick();
      @(posedge sys_clk);
      for (int k = 0; k < 6; k++) drv[k] <= st[k];
      wd <= swd;
      we <= swe;
      wait_pad <= spad;
      @(posedge sys_clk);
      for (int k = 0; k < 6; k++) drv[k] <= '0;
      wd <= 1'b0;
      we <= 1'b0;
      own = (own & ~st[1]) | st[0];
      selb = (selb & ~st[2]) | st[3];
      pu = (pu & ~st[4]) | st[5];
      wa = (wa & ~swd) | swe;
      for (int k = 0; k < 6; k++) st[k] = '0;
      swd = 1'b0;
      swe = 1'b0;
      @(posedge sys_clk);
      #1;
      for (int c = 0; c < 3; c++)
         for (int l = 0; l < 32; l++)
            ep[c][l] = own[c][l] ? (selb[c][l] ? bd[c][l] : ad[c][l])
                                 : gd[c][l];
      chk(192'(osr), 192'(own));
      chk(192'(bsr), 192'(selb));
      chk(192'(puo), 192'(pu));
      chk(pd, ep);
      chk(192'(wact), 192'(wa));
      ew = own[2][2] & ~selb[2][2] & wa & ~wait_pad;
      chk(192'(wreq), 192'(ew));
   endtask
   task automatic expect_reset();
      own = {RESET_OWNER_THIRD, RESET_OTHER, RESET_OWNER_FIRST};
      selb = {RESET_OTHER, RESET_OTHER, RESET_SELECT_B};
      pu = '1;
      wa = 1'b1;
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      for (int k = 0; k < 6; k++) drv[k] = '0;
      for (int k = 0; k < 6; k++) st[k] = '0;
      swd = 1'b0;
      swe = 1'b0;
      spad = 1'b0;
      expect_reset();
      repeat (8) @(posedge sys_clk);
      reset_n <= 1'b1;
      tick();
      arm(0, 1, 32'h00000020);
      tick();
      arm(3, 1, 32'h00000020);
      tick();
      arm(2, 1, 32'h00000020);
      arm(1, 1, 32'h00000020);
      tick();
      for (int k = 0; k < 4; k++) arm(k, 0, 32'h0000007F);
      tick();
      arm(2, 0, 32'h0000007F);
      tick();
      arm(0, 1, 32'h1FFFFFF0);
      arm(3, 1, 32'h1FFFFFF0);
      tick();
      arm(4, 0, 32'hFFFFFFFF);
      arm(5, 0, 32'h0000FFFF);
      tick();
      arm(5, 0, 32'hFFFF0000);
      tick();
      arm(0, 2, 32'h00000004);
      arm(2, 2, 32'h00000004);
      tick();
      swd = 1'b1;
      tick();
      swd = 1'b1;
      swe = 1'b1;
      tick();
      arm(3, 2, 32'h00000004);
      tick();
      arm(2, 2, 32'h00000004);
      spad = 1'b1;
      tick();
      spad = 1'b0;
      tick();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      reset_n <= 1'b1;
      expect_reset();
      tick();
      wrap_up();
   end
endmodule
